/* inc/fssr_cfg.svh */
`ifndef FSSR_CFG_SVH
`define FSSR_CFG_SVH

// System clock period
`define FSSR_CLK_NS         25
// Suspend latencies in ns, plain defaults
`define FSSR_PROG_LAT_NS    20000
`define FSSR_ERASE_LAT_NS   20000
`define FSSR_PROG_LAT_CYC   ((`FSSR_PROG_LAT_NS + `FSSR_CLK_NS - 1) / `FSSR_CLK_NS)
`define FSSR_ERASE_LAT_CYC  ((`FSSR_ERASE_LAT_NS + `FSSR_CLK_NS - 1) / `FSSR_CLK_NS)
// Host-side waits in ns, plain defaults; the device does not police them
`define FSSR_PROG_RESUME_WAIT_NS   20000
`define FSSR_PROG_RESUME_WAIT_CYC  ((`FSSR_PROG_RESUME_WAIT_NS + `FSSR_CLK_NS - 1) / `FSSR_CLK_NS)
`define FSSR_RESET_RECOVERY_NS     40000
`define FSSR_RESET_RECOVERY_CYC    ((`FSSR_RESET_RECOVERY_NS + `FSSR_CLK_NS - 1) / `FSSR_CLK_NS)
// High-voltage select hold: supply settle, setup and extra setup
`define FSSR_SUPPLY_SETTLE_NS      800000
`define FSSR_HV_SETUP_NS           250
`define FSSR_HV_EXTRA_NS           0
`define FSSR_HV_HOLD_NS            (`FSSR_SUPPLY_SETTLE_NS + `FSSR_HV_SETUP_NS + `FSSR_HV_EXTRA_NS)
`define FSSR_HV_CS_WAIT_CYC        ((`FSSR_HV_HOLD_NS + `FSSR_CLK_NS - 1) / `FSSR_CLK_NS)

// Command codes
`define FSSR_CMD_READ       8'h03
`define FSSR_CMD_FAST_READ  8'h0b
`define FSSR_CMD_DUAL_OUT   8'h3b
`define FSSR_CMD_QUAD_OUT   8'h6b
`define FSSR_CMD_DUAL_IO    8'hbb
`define FSSR_CMD_QUAD_IO    8'heb
`define FSSR_CMD_PARAM_TBL  8'h5a
`define FSSR_CMD_IDENT      8'h9f
`define FSSR_CMD_MAKER_DEV  8'h90
`define FSSR_CMD_BURST_LEN  8'hc0
`define FSSR_CMD_OTP_ENTER  8'hb1
`define FSSR_CMD_OTP_EXIT   8'hc1
`define FSSR_CMD_WL_SET     8'h06
`define FSSR_CMD_WL_CLEAR   8'h04
`define FSSR_CMD_PAGE_PROG  8'h02
`define FSSR_CMD_QUAD_PROG  8'h38
`define FSSR_CMD_RESUME_A   8'h7a
`define FSSR_CMD_RESUME_B   8'h30
`define FSSR_CMD_SUSPEND    8'hb0
`define FSSR_CMD_STATUS_RD  8'h05
`define FSSR_CMD_CONFIG_RD  8'h15
`define FSSR_CMD_SECUR_RD   8'h2b
`define FSSR_CMD_SIGN_RD    8'hab
`define FSSR_CMD_RST_ARM    8'h66
`define FSSR_CMD_RST        8'h99
`define FSSR_CMD_NOP        8'h00

// Region masks per operation kind
`define FSSR_MASK_PAGE      24'h0000ff
`define FSSR_MASK_4K        24'h000fff
`define FSSR_MASK_32K       24'h007fff
`define FSSR_MASK_64K       24'h00ffff

// Wishbone register byte offsets
`define FSSR_STATUS_OFS     8'h00
`define FSSR_CTRL_OFS       8'h04
`define FSSR_SECUR_OFS      8'h08
// Security register bit positions
`define FSSR_SEC_PROG_BIT   2
`define FSSR_SEC_ERASE_BIT  3

`endif

/* inc/fssr_pkg.sv */
package fssr_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUSY,
		ST_PAUSING,
		ST_PAUSED,
		ST_NESTED
	} fssr_state_type;

	typedef struct packed {
		fssr_state_type state;
		logic [15:0]    lat_cnt;
		logic           write_latch_flag;
		logic           op_in_progress_flag;
		logic           program_paused_flag;
		logic           erase_paused_flag;
		logic           armed;
		logic           erase_op;
		logic [1:0]     kind;
		logic [23:0]    addr;
		logic           perf;
		logic           accept;
		logic           reject;
		logic           pause;
		logic           resume;
		logic           abort;
		logic           nested;
		logic           rd_blocked;
		logic           ack;
		logic [31:0]    dat;
	} fssr_core_type;

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic       sclk_d;
		logic [2:0] bit_cnt;
		logic       first;
		logic [7:0] shift;
		logic       valid;
		logic [7:0] code;
	} fssr_rx_type;

endpackage : fssr_pkg

/* rtl/fssr_link_rx.sv */
`timescale 1ns/1ps
`include "fssr_cfg.svh"

module fssr_link_rx (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cs_n_i,
	input  wire logic       sclk_i,
	input  wire logic       si_i,
	output logic            cmd_valid_o,
	output logic [7:0]      cmd_code_o
);

	fssr_pkg::fssr_rx_type r_r;
	fssr_pkg::fssr_rx_type r_nxt;

	// Pins sync, then edge find on the second stage only
	always_comb begin
		r_nxt       = r_r;
		r_nxt.valid = 1'b0;
		r_nxt.sync1 = {cs_n_i, sclk_i, si_i};
		r_nxt.sync2 = r_r.sync1;
		r_nxt.sclk_d = r_r.sync2[1];
		if (r_r.sync2[2]) begin
			// Deselect restarts the opcode byte
			r_nxt.bit_cnt = 3'h0;
			r_nxt.first   = 1'b1;
		end else if (r_r.sync2[1] && !r_r.sclk_d) begin
			r_nxt.shift   = {r_r.shift[6:0], r_r.sync2[0]};
			r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
			if (r_r.bit_cnt == 3'h7 && r_r.first) begin
				// Only the first byte of a frame is an opcode
				r_nxt.valid = 1'b1;
				r_nxt.code  = {r_r.shift[6:0], r_r.sync2[0]};
				r_nxt.first = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_r <= '{sync1: 3'h7, sync2: 3'h7, sclk_d: 1'b0, bit_cnt: 3'h0, first: 1'b1,
				shift: 8'h00, valid: 1'b0, code: 8'h00};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign cmd_valid_o = r_r.valid;
	assign cmd_code_o  = r_r.code;

endmodule : fssr_link_rx

/* rtl/fssr_core.sv */
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "fssr_cfg.svh"

module fssr_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic        si_i,
	input  wire logic        op_start_i,
	input  wire logic        op_is_erase_i,
	input  wire logic [1:0]  op_kind_i,
	input  wire logic [23:0] op_addr_i,
	input  wire logic        op_done_i,
	input  wire logic [23:0] rd_addr_i,
	input  wire logic [23:0] nest_addr_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	output logic             write_latch_flag_o,
	output logic             op_in_progress_flag_o,
	output logic             program_paused_flag_o,
	output logic             erase_paused_flag_o,
	output logic             cmd_accept_o,
	output logic             cmd_reject_o,
	output logic             engine_pause_o,
	output logic             engine_resume_o,
	output logic             engine_abort_o,
	output logic             nested_prog_start_o,
	output logic             rd_blocked_o
);

	localparam logic [15:0] PROG_LAT  = 16'(`FSSR_PROG_LAT_CYC);
	localparam logic [15:0] ERASE_LAT = 16'(`FSSR_ERASE_LAT_CYC);

	fssr_pkg::fssr_core_type r_r;
	fssr_pkg::fssr_core_type r_nxt;
	logic                    cmd_valid;
	logic                    bus_ack;
	logic [31:0]             bus_dat;
	logic [7:0]              cmd_code;

	// Region test shared by read blocking and nested program check
	function automatic logic in_region(input logic [23:0] a, input logic [23:0] base,
		input logic [1:0] kind);
		logic [23:0] m;
		m = (kind == 2'h0) ? `FSSR_MASK_PAGE :
			(kind == 2'h1) ? `FSSR_MASK_4K :
			(kind == 2'h2) ? `FSSR_MASK_32K : `FSSR_MASK_64K;
		in_region = ((a & ~m) == (base & ~m));
	endfunction : in_region

	// Power-on values of every volatile bit
	function automatic fssr_pkg::fssr_core_type core_reset();
		fssr_pkg::fssr_core_type v;
		v = '0;
		v.state = fssr_pkg::ST_IDLE;
		core_reset = v;
	endfunction : core_reset

	// Commands that must wait for the suspend latency
	function automatic logic is_latency_cmd(input logic [7:0] c);
		is_latency_cmd = (c == `FSSR_CMD_READ) || (c == `FSSR_CMD_FAST_READ) ||
			(c == `FSSR_CMD_DUAL_OUT) || (c == `FSSR_CMD_QUAD_OUT) ||
			(c == `FSSR_CMD_DUAL_IO) || (c == `FSSR_CMD_QUAD_IO) ||
			(c == `FSSR_CMD_PARAM_TBL) || (c == `FSSR_CMD_IDENT) ||
			(c == `FSSR_CMD_MAKER_DEV) || (c == `FSSR_CMD_BURST_LEN) ||
			(c == `FSSR_CMD_OTP_ENTER) || (c == `FSSR_CMD_OTP_EXIT);
	endfunction : is_latency_cmd

	// Commands served at any time after a suspend
	function automatic logic is_free_cmd(input logic [7:0] c);
		is_free_cmd = (c == `FSSR_CMD_WL_CLEAR) || (c == `FSSR_CMD_STATUS_RD) ||
			(c == `FSSR_CMD_CONFIG_RD) || (c == `FSSR_CMD_SECUR_RD) ||
			(c == `FSSR_CMD_SIGN_RD);
	endfunction : is_free_cmd

	// Either resume code
	function automatic logic is_resume(input logic [7:0] c);
		is_resume = (c == `FSSR_CMD_RESUME_A) || (c == `FSSR_CMD_RESUME_B);
	endfunction : is_resume

	// Opcode receiver on the sampled link pins
	fssr_link_rx u_rx (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.cs_n_i      (cs_n_i),
		.sclk_i      (sclk_i),
		.si_i        (si_i),
		.cmd_valid_o (cmd_valid),
		.cmd_code_o  (cmd_code)
	);

	// Next-state logic for bus, operation tracking and commands
	always_comb begin
		r_nxt        = r_r;
		r_nxt.accept = 1'b0;
		r_nxt.reject = 1'b0;
		r_nxt.pause  = 1'b0;
		r_nxt.resume = 1'b0;
		r_nxt.abort  = 1'b0;
		r_nxt.nested = 1'b0;
		r_nxt.ack    = 1'b0;

		// Wishbone slave, one wait state, ack drops after one cycle
		if (wb_cyc_i && wb_stb_i && !r_r.ack) begin
			r_nxt.ack = 1'b1;
			r_nxt.dat = 32'h0000_0000;
			if (wb_adr_i == `FSSR_STATUS_OFS) begin
				r_nxt.dat = {25'h0, r_r.state, r_r.erase_paused_flag, r_r.program_paused_flag, r_r.write_latch_flag, r_r.op_in_progress_flag};
			end else if (wb_adr_i == `FSSR_CTRL_OFS) begin
				r_nxt.dat = {31'h0, r_r.perf};
				if (wb_we_i && wb_sel_i[0]) begin
					r_nxt.perf = wb_dat_i[0];
				end
			end else if (wb_adr_i == `FSSR_SECUR_OFS) begin
				r_nxt.dat[`FSSR_SEC_PROG_BIT]  = r_r.program_paused_flag;
				r_nxt.dat[`FSSR_SEC_ERASE_BIT] = r_r.erase_paused_flag;
			end
		end

		// Bus answer of this cycle survives a software reset in the same cycle
		bus_ack = r_nxt.ack;
		bus_dat = r_nxt.dat;

		// Reads into the halted page, sector or block are refused
		r_nxt.rd_blocked = (r_r.program_paused_flag || r_r.erase_paused_flag) && in_region(rd_addr_i, r_r.addr, r_r.kind);

		// Operation tracking and suspend latency
		case (r_r.state)
			fssr_pkg::ST_IDLE: begin
				if (op_start_i && r_r.write_latch_flag) begin
					r_nxt.state    = fssr_pkg::ST_BUSY;
					r_nxt.op_in_progress_flag      = 1'b1;
					r_nxt.erase_op = op_is_erase_i;
					r_nxt.kind     = op_kind_i;
					r_nxt.addr     = op_addr_i;
				end
			end
			fssr_pkg::ST_BUSY: begin
				if (op_done_i) begin
					r_nxt.state = fssr_pkg::ST_IDLE;
					r_nxt.op_in_progress_flag   = 1'b0;
					r_nxt.write_latch_flag   = 1'b0;
				end
			end
			fssr_pkg::ST_PAUSING: begin
				if (r_r.lat_cnt == 16'h0001) begin
					// Flags change only once the engine has really stopped
					r_nxt.state = fssr_pkg::ST_PAUSED;
					r_nxt.write_latch_flag   = 1'b0;
					r_nxt.op_in_progress_flag   = 1'b0;
					r_nxt.program_paused_flag   = !r_r.erase_op;
					r_nxt.erase_paused_flag   = r_r.erase_op;
				end
				r_nxt.lat_cnt = r_r.lat_cnt - 16'h0001;
			end
			fssr_pkg::ST_NESTED: begin
				if (op_done_i) begin
					r_nxt.state = fssr_pkg::ST_PAUSED;
					r_nxt.op_in_progress_flag   = 1'b0;
					r_nxt.write_latch_flag   = 1'b0;
				end
			end
			default: begin
			end
		endcase

		// Command handling; any opcode drops a pending arm
		if (cmd_valid) begin
			r_nxt.armed = 1'b0;
			if (cmd_code == `FSSR_CMD_RST) begin
				if (r_r.armed) begin
					// Clears everything but the bus answer, perf mode included
					r_nxt        = core_reset();
					r_nxt.ack    = bus_ack;
					r_nxt.dat    = bus_dat;
					r_nxt.abort  = r_r.op_in_progress_flag || r_r.program_paused_flag || r_r.erase_paused_flag;
					r_nxt.accept = 1'b1;
				end else begin
					r_nxt.reject = 1'b1;
				end
			end else if (cmd_code == `FSSR_CMD_RST_ARM) begin
				r_nxt.armed  = 1'b1;
				r_nxt.accept = 1'b1;
			end else if (cmd_code == `FSSR_CMD_NOP) begin
				r_nxt.accept = 1'b1;
			end else if (is_free_cmd(cmd_code)) begin
				r_nxt.accept = 1'b1;
				if (cmd_code == `FSSR_CMD_WL_CLEAR &&
					r_r.state != fssr_pkg::ST_BUSY && r_r.state != fssr_pkg::ST_NESTED) begin
					r_nxt.write_latch_flag = 1'b0;
				end
			end else begin
				case (r_r.state)
					fssr_pkg::ST_IDLE: begin
						// Suspend with nothing running leaves flags alone
						if (cmd_code == `FSSR_CMD_WL_SET) begin
							r_nxt.write_latch_flag    = 1'b1;
							r_nxt.accept = 1'b1;
						end else if (cmd_code != `FSSR_CMD_SUSPEND) begin
							r_nxt.accept = 1'b1;
						end
					end
					fssr_pkg::ST_BUSY: begin
						if (cmd_code == `FSSR_CMD_SUSPEND) begin
							r_nxt.state   = fssr_pkg::ST_PAUSING;
							r_nxt.lat_cnt = r_r.erase_op ? ERASE_LAT : PROG_LAT;
							r_nxt.pause   = 1'b1;
							r_nxt.accept  = 1'b1;
						end else begin
							r_nxt.reject  = 1'b1;
						end
					end
					fssr_pkg::ST_PAUSED: begin
						if (is_latency_cmd(cmd_code)) begin
							r_nxt.accept = 1'b1;
						end else if (is_resume(cmd_code) && !r_r.perf) begin
							r_nxt.state  = fssr_pkg::ST_BUSY;
							r_nxt.write_latch_flag    = 1'b1;
							r_nxt.op_in_progress_flag    = 1'b1;
							r_nxt.program_paused_flag    = 1'b0;
							r_nxt.erase_paused_flag    = 1'b0;
							r_nxt.resume = 1'b1;
							r_nxt.accept = 1'b1;
						end else if (cmd_code == `FSSR_CMD_WL_SET && r_r.erase_paused_flag) begin
							r_nxt.write_latch_flag    = 1'b1;
							r_nxt.accept = 1'b1;
						end else if ((cmd_code == `FSSR_CMD_PAGE_PROG || cmd_code == `FSSR_CMD_QUAD_PROG) &&
							r_r.erase_paused_flag && r_r.write_latch_flag && !in_region(nest_addr_i, r_r.addr, r_r.kind)) begin
							r_nxt.state  = fssr_pkg::ST_NESTED;
							r_nxt.op_in_progress_flag    = 1'b1;
							r_nxt.nested = 1'b1;
							r_nxt.accept = 1'b1;
						end else begin
							// Perf-mode resume lands here too
							r_nxt.reject = 1'b1;
						end
					end
					default: begin
						// Pausing: latency not over; nested: no suspend or resume
						r_nxt.reject = 1'b1;
					end
				endcase
			end
		end
	end

	// Single state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_r <= core_reset();
		end else begin
			r_r <= r_nxt;
		end
	end

	// Outputs straight from the state register
	assign wb_ack_o              = r_r.ack;
	assign wb_dat_o              = r_r.dat;
	assign write_latch_flag_o    = r_r.write_latch_flag;
	assign op_in_progress_flag_o = r_r.op_in_progress_flag;
	assign program_paused_flag_o = r_r.program_paused_flag;
	assign erase_paused_flag_o   = r_r.erase_paused_flag;
	assign cmd_accept_o          = r_r.accept;
	assign cmd_reject_o          = r_r.reject;
	assign engine_pause_o        = r_r.pause;
	assign engine_resume_o       = r_r.resume;
	assign engine_abort_o        = r_r.abort;
	assign nested_prog_start_o   = r_r.nested;
	assign rd_blocked_o          = r_r.rd_blocked;

	// Checks on flags, command decode and bus timing
	a_latency_end_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_r.state == fssr_pkg::ST_PAUSING && r_r.lat_cnt == 16'h0001)
		|=> !r_r.write_latch_flag && (r_r.program_paused_flag != r_r.erase_paused_flag)) else $error("pause flags wrong after latency");
	a_flags_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
		!(r_r.program_paused_flag && r_r.erase_paused_flag)) else $error("both paused flags set");
	a_prog_no_write_latch_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && cmd_code == `FSSR_CMD_WL_SET && r_r.state == fssr_pkg::ST_PAUSED && r_r.program_paused_flag)
		|=> r_r.reject && !r_r.write_latch_flag) else $error("latch set during program pause");
	a_resume_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(r_r.resume) |-> r_r.write_latch_flag && r_r.op_in_progress_flag && !r_r.program_paused_flag && !r_r.erase_paused_flag)
		else $error("resume did not set latch and busy");
	a_nested_no_resume: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && is_resume(cmd_code) && r_r.state == fssr_pkg::ST_NESTED)
		|=> !r_r.resume && r_r.state == fssr_pkg::ST_NESTED) else $error("nested program resumed");
	a_nested_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		(r_r.state == fssr_pkg::ST_NESTED) |-> r_r.write_latch_flag && r_r.op_in_progress_flag) else $error("nested flags low");
	a_perf_resume: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && is_resume(cmd_code) && r_r.perf) |=> !r_r.resume) else $error("resume in perf mode");
	a_nop_disarms: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && cmd_code == `FSSR_CMD_NOP)
		|=> !r_r.armed && r_r.accept) else $error("no-op left reset armed");
	a_idle_suspend: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && cmd_code == `FSSR_CMD_SUSPEND && r_r.state == fssr_pkg::ST_IDLE)
		|=> r_r.state == fssr_pkg::ST_IDLE && !r_r.pause && !r_r.program_paused_flag && !r_r.erase_paused_flag)
		else $error("idle suspend changed state");
	a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && cmd_code == `FSSR_CMD_RST && r_r.armed)
		|=> r_r.state == fssr_pkg::ST_IDLE && !r_r.write_latch_flag && !r_r.op_in_progress_flag && !r_r.program_paused_flag && !r_r.erase_paused_flag)
		else $error("reset left state set");
	a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !r_r.ack) |=> r_r.ack ##1 !r_r.ack) else $error("bad ack timing");
	a_rst_needs_arm: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && cmd_code == `FSSR_CMD_RST && !r_r.armed)
		|=> r_r.reject && !r_r.accept && !r_r.abort) else $error("reset ran without arm");
	a_paused_read_block: assert property (@(posedge clk_i) disable iff (rst_i)
		((r_r.program_paused_flag || r_r.erase_paused_flag) && !cmd_valid && in_region(rd_addr_i, r_r.addr, r_r.kind))
		|=> r_r.rd_blocked) else $error("read into halted region not blocked");
	a_suspend_pause: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_valid && cmd_code == `FSSR_CMD_SUSPEND && r_r.state == fssr_pkg::ST_BUSY)
		|=> r_r.pause && r_r.state == fssr_pkg::ST_PAUSING) else $error("suspend did not halt operation");

endmodule : fssr_core

/* sim/fssr_host_model.sv */
`timescale 1ns/1ps

// Host end of the link: one opcode byte per frame, sclk period 200 ns
module fssr_host_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       send_i,
	input  wire logic [7:0] code_i,
	output logic            cs_n_o,
	output logic            sclk_o,
	output logic            si_o,
	output logic            busy_o
);
	logic [7:0] shift_r;
	logic [2:0] bit_r;
	logic [1:0] ph_r;

	// Four system clocks per half period; sclk rests low outside frames
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_n_o <= 1'b1;
			sclk_o <= 1'b0;
			si_o <= 1'b0;
			busy_o <= 1'b0;
			bit_r <= 3'h0;
			ph_r <= 2'h0;
			shift_r <= 8'h00;
		end else if (!busy_o && send_i) begin
			busy_o <= 1'b1;
			cs_n_o <= 1'b0;
			shift_r <= code_i;
			si_o <= code_i[7];
			bit_r <= 3'h0;
			ph_r <= 2'h0;
		end else if (busy_o) begin
			ph_r <= ph_r + 2'h1;
			if (ph_r == 2'h3) begin
				sclk_o <= ~sclk_o;
				// Data moves on the falling edge so it is steady at the rising one
				if (sclk_o && bit_r == 3'h7) begin
					cs_n_o <= 1'b1;
					busy_o <= 1'b0;
					si_o <= ~si_o; // Released line shows no stale bit
				end else if (sclk_o) begin
					shift_r <= {shift_r[6:0], 1'b0};
					si_o <= shift_r[6];
					bit_r <= bit_r + 3'h1;
				end
			end
		end
	end
endmodule : fssr_host_model

/* sim/flash_suspend_resume_reset_bench.sv */
`timescale 1ns/1ps
`include "fssr_cfg.svh"

module flash_suspend_resume_reset_bench;
	logic        clk_i, rst_i, send, busy, cs_n, sclk, si;
	logic [7:0]  code, wb_adr_i;
	logic        op_start_i, op_is_erase_i, op_done_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [1:0]  op_kind_i;
	logic [23:0] op_addr_i, rd_addr_i, nest_addr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        wl, op_in_progress_flag, program_paused_flag, erase_paused_flag, acc, rej, pau, res, abt, nst, blk;
	int          n_mismatch, total_checks, cnt[6], snap[6];
	logic [7:0]  rdc[12] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h5a, 8'h9f, 8'h90, 8'hc0, 8'hb1, 8'hc1};
	logic [7:0]  frc[4] = '{8'h05, 8'h15, 8'h2b, 8'hab};
	logic [7:0]  prc[3] = '{8'h06, 8'h02, 8'h38};
	wire  [5:0]  ev = {nst, abt, res, pau, rej, acc};

	initial begin
		{send, code, op_start_i, op_is_erase_i, op_done_i, op_kind_i, op_addr_i} = '0;
		{rd_addr_i, nest_addr_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		rst_i = 1'b1;
	end

	// System clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	fssr_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .code_i(code), .cs_n_o(cs_n),
		.sclk_o(sclk), .si_o(si), .busy_o(busy));

	fssr_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
		.op_start_i(op_start_i), .op_is_erase_i(op_is_erase_i), .op_kind_i(op_kind_i), .op_addr_i(op_addr_i),
		.op_done_i(op_done_i), .rd_addr_i(rd_addr_i), .nest_addr_i(nest_addr_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .write_latch_flag_o(wl), .op_in_progress_flag_o(op_in_progress_flag),
		.program_paused_flag_o(program_paused_flag), .erase_paused_flag_o(erase_paused_flag), .cmd_accept_o(acc), .cmd_reject_o(rej),
		.engine_pause_o(pau), .engine_resume_o(res), .engine_abort_o(abt), .nested_prog_start_o(nst),
		.rd_blocked_o(blk));

	// Pulse tally mid-cycle; pulses last one cycle so each is counted once
	always @(negedge clk_i) begin
		for (int i = 0; i < 6; i++) cnt[i] += ev[i];
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle; request held until ack is sampled
	task wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= wd;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		// Ack one cycle after the taking edge; only the watchdog ends a hang
		chk(32'(i), 32'h2);
	endtask : wb

	// One opcode frame; e lists expected pulses, 3f skips the compare
	task cmd(input logic [7:0] c, input logic [5:0] e);
		logic [5:0] d;
		int i;
		snap = cnt;
		@(posedge clk_i);
		send <= 1'b1;
		code <= c;
		@(posedge clk_i);
		send <= 1'b0;
		@(posedge clk_i);
		i = 0;
		while (busy && i < 200) begin
			@(posedge clk_i);
			i++;
		end
		repeat (8) @(posedge clk_i);
		for (i = 0; i < 6; i++) d[i] = (cnt[i] - snap[i]) == 1;
		if (e !== 6'h3f) chk({26'h0, d}, {26'h0, e});
	endtask : cmd

	task fl(input logic [3:0] e);
		@(negedge clk_i);
		chk({28'h0, wl, op_in_progress_flag, program_paused_flag, erase_paused_flag}, {28'h0, e});
	endtask : fl

	task eng(input logic st, input logic dn);
		@(posedge clk_i);
		op_start_i <= st;
		op_done_i <= dn;
		@(posedge clk_i);
		op_start_i <= 1'b0;
		op_done_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : eng

	task bl(input logic [23:0] a, input logic e);
		@(posedge clk_i);
		rd_addr_i <= a;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({31'h0, blk}, {31'h0, e});
	endtask : bl

	task conclude;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// Hang guard: select-hold wait plus generous margin for the tests
	initial begin
		repeat (`FSSR_HV_CS_WAIT_CYC + 30000) @(posedge clk_i);
		n_mismatch++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `FSSR_SECUR_OFS, 32'h0, rd); chk(rd, 32'h0);
		wb(1'b0, 8'hfc, 32'h0, rd); chk(rd, 32'h0);
		// Select stays high through the high-voltage setup before any frame
		repeat (`FSSR_HV_CS_WAIT_CYC) @(posedge clk_i);
		cmd(`FSSR_CMD_SUSPEND, 6'h00);
		fl(4'b0000);
		// Sector erase, paused, nested program, resume
		cmd(8'h06, 6'h01);
		op_is_erase_i <= 1'b1;
		op_kind_i <= 2'd1;
		op_addr_i <= 24'h012345;
		eng(1'b1, 1'b0);
		cmd(`FSSR_CMD_SUSPEND, 6'h05);
		cmd(8'h03, 6'h02);
		foreach (frc[k]) cmd(frc[k], 6'h01);
		repeat (810) @(posedge clk_i);
		fl(4'b0001);
		wb(1'b0, `FSSR_SECUR_OFS, 32'h0, rd); chk(rd, 32'h8);
		bl(24'h012abc, 1'b1);
		bl(24'h013000, 1'b0);
		foreach (rdc[k]) cmd(rdc[k], 6'h01);
		cmd(8'h06, 6'h01);
		nest_addr_i <= 24'h012100;
		cmd(8'h02, 6'h02);
		nest_addr_i <= 24'h200000;
		cmd(8'h06, 6'h01);
		cmd(8'h38, 6'h21);
		fl(4'b1101);
		cmd(8'h7a, 6'h02);
		cmd(`FSSR_CMD_SUSPEND, 6'h02);
		eng(1'b0, 1'b1);
		fl(4'b0001);
		wb(1'b1, `FSSR_CTRL_OFS, 32'h1, rd);
		cmd(8'h7a, 6'h02);
		fl(4'b0001);
		wb(1'b1, `FSSR_CTRL_OFS, 32'h0, rd);
		cmd(8'h30, 6'h09);
		fl(4'b1100);
		eng(1'b0, 1'b1);
		// Page program, paused, resume, then software reset
		cmd(8'h06, 6'h01);
		op_is_erase_i <= 1'b0;
		op_kind_i <= 2'd0;
		op_addr_i <= 24'h000140;
		eng(1'b1, 1'b0);
		cmd(`FSSR_CMD_SUSPEND, 6'h05);
		repeat (810) @(posedge clk_i);
		fl(4'b0010);
		wb(1'b0, `FSSR_SECUR_OFS, 32'h0, rd); chk(rd, 32'h4);
		bl(24'h0001ff, 1'b1);
		bl(24'h000200, 1'b0);
		foreach (prc[k]) cmd(prc[k], 6'h02);
		cmd(8'h0b, 6'h01);
		cmd(8'h7a, 6'h09);
		fl(4'b1100);
		// Second suspend only after the resume-to-suspend wait; reset then hits it
		repeat (`FSSR_PROG_RESUME_WAIT_CYC) @(posedge clk_i);
		cmd(`FSSR_CMD_SUSPEND, 6'h05);
		fl(4'b1100);
		wb(1'b1, `FSSR_CTRL_OFS, 32'h1, rd);
		cmd(8'h99, 6'h02);
		cmd(8'h66, 6'h01);
		cmd(8'h00, 6'h01);
		cmd(8'h99, 6'h02);
		cmd(8'h66, 6'h01);
		cmd(8'h99, 6'h11);
		fl(4'b0000);
		wb(1'b0, `FSSR_CTRL_OFS, 32'h0, rd); chk(rd, 32'h0);
		repeat (`FSSR_RESET_RECOVERY_CYC) @(posedge clk_i);
		cmd(8'h06, 6'h01);
		fl(4'b1000);
		// High voltage may be dropped only once busy reads low
		chk({31'h0, op_in_progress_flag}, 32'h0);
		conclude();
	end
endmodule : flash_suspend_resume_reset_bench
